// file: src/secp_core.sv
// Serial EEPROM command decoder, status register and write protection
`timescale 1ns/1ns
`default_nettype none
module secp_core
  import secp_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES,
  parameter int MEM_DEPTH = 65536
) (
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Protect pin
  input wire logic wp_n,
  // Status view
  output logic [7:0] status_byte
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] mem [0:MEM_DEPTH-1];
  secp_state_t s_ff, nxt_s;

  // Status byte assembled from live bits
  function automatic logic [7:0] st_of(input secp_state_t x);
    logic [7:0] v;
    v = 8'h00;
    v[ST_PROT_EN] = x.prot_en;
    v[ST_FLAG] = x.flag;
    v[ST_LOCK_HI] = x.lock[1];
    v[ST_LOCK_LO] = x.lock[0];
    v[ST_LATCH] = x.latch;
    v[ST_BUSY] = x.busy;
    return v;
  endfunction

  // True when the address is in the locked range
  function automatic logic locked(input logic [1:0] lk, input logic [15:0] a);
    logic r;
    r = 1'b0;
    unique case (lk)
      2'b01: r = (a >= LOCK_QUARTER_BASE) && (a <= LOCK_TOP);
      2'b10: r = (a >= LOCK_HALF_BASE) && (a <= LOCK_TOP);
      2'b11: r = (a >= LOCK_ALL_BASE) && (a <= LOCK_TOP);
      2'b00: r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic cs_low, cs_fall, cs_rise, sck_rise, sck_fall, sbit;
  logic [15:0] addr_next;
  assign cs_low = ~s_ff.cs_sync[1];
  assign cs_fall = s_ff.cs_sync[2] & ~s_ff.cs_sync[1];
  assign cs_rise = ~s_ff.cs_sync[2] & s_ff.cs_sync[1];
  assign sck_rise = ~s_ff.sck_sync[2] & s_ff.sck_sync[1];
  assign sck_fall = s_ff.sck_sync[2] & ~s_ff.sck_sync[1];
  assign sbit = s_ff.si_sync[1];
  assign addr_next = s_ff.addr + 16'h0001;

  // Edges only come from the second and third sync stages, so a stopped clock just waits
  always_comb begin
    nxt_s = s_ff;
    nxt_s.cs_sync = {s_ff.cs_sync[1:0], cs_n};
    nxt_s.sck_sync = {s_ff.sck_sync[1:0], sck};
    nxt_s.si_sync = {s_ff.si_sync[0], si};
    nxt_s.wp_sync = {s_ff.wp_sync[0], wp_n};
    nxt_s.mem_we = 1'b0;
    // Internal write timer
    if (s_ff.busy) begin
      if (s_ff.busy_cnt == 32'(WRITE_CYCLES_P - 1)) begin
        nxt_s.busy = 1'b0;
        nxt_s.latch = 1'b0;
        if (s_ff.is_status_wr) begin
          // Commit even if protect pin dropped meanwhile
          nxt_s.prot_en = s_ff.st_new[ST_PROT_EN];
          nxt_s.lock = s_ff.st_new[ST_LOCK_HI:ST_LOCK_LO];
        end
      end else begin
        nxt_s.busy_cnt = s_ff.busy_cnt + 32'h1;
      end
    end
    if (cs_fall) begin
      // Fresh transaction; first sampled rise is the first bit
      nxt_s.phase = SECP_IDLE;
      nxt_s.bitcnt = 5'h00;
      nxt_s.opcode_done = 1'b0;
      nxt_s.byte_ok = 1'b0;
      nxt_s.wr_pending = 1'b0;
    end else if (cs_rise) begin
      nxt_s.out.so_oe = 1'b0;
      // Write launches only when the select rises on a byte boundary
      if (s_ff.wr_pending && s_ff.byte_ok && s_ff.bitcnt == 5'h00 && !s_ff.busy) begin
        nxt_s.busy = 1'b1;
        nxt_s.busy_cnt = 32'h0;
      end
    end else if (cs_low && sck_rise) begin
      nxt_s.shreg = {s_ff.shreg[6:0], sbit};
      nxt_s.bitcnt = s_ff.bitcnt + 5'h01;
      nxt_s.byte_ok = 1'b0;
      unique case (s_ff.phase)
        SECP_IDLE: if (s_ff.bitcnt == BYTE_BITS - 5'h01) begin
          nxt_s.opcode = {s_ff.shreg[6:0], sbit};
          nxt_s.opcode_done = 1'b1;
          nxt_s.bitcnt = 5'h00;
          nxt_s.phase = SECP_SKIP;
          unique case ({s_ff.shreg[6:0], sbit})
            OP_LATCH_SET: if (!s_ff.busy) nxt_s.latch = 1'b1;
            OP_LATCH_CLEAR: if (!s_ff.busy) begin
              nxt_s.latch = 1'b0;
              nxt_s.flag = 1'b0;
            end
            OP_FLAG_SET: nxt_s.flag = 1'b1;
            OP_STATUS_READ: begin
              nxt_s.phase = SECP_RDATA;
              nxt_s.txbyte = st_of(s_ff);
            end
            OP_ARRAY_READ: if (!s_ff.busy) nxt_s.phase = SECP_ADDR;
            OP_ARRAY_WRITE: if (!s_ff.busy && s_ff.latch) nxt_s.phase = SECP_ADDR;
            OP_STATUS_WRITE:
              // Locked mode: pin low and enable set refuses status writes
              if (!s_ff.busy && s_ff.latch &&
                  !(s_ff.prot_en && !s_ff.wp_sync[1])) nxt_s.phase = SECP_SDATA;
            default: nxt_s.phase = SECP_SKIP;
          endcase
        end
        SECP_ADDR: begin
          nxt_s.addr = {s_ff.addr[14:0], sbit};
          if (s_ff.bitcnt == ADDR_BITS - 5'h01) begin
            nxt_s.bitcnt = 5'h00;
            if (s_ff.opcode == OP_ARRAY_READ) begin
              nxt_s.phase = SECP_RDATA;
              nxt_s.txbyte = mem[{s_ff.addr[14:0], sbit}];
            end else begin
              nxt_s.phase = SECP_WDATA;
            end
          end
        end
        SECP_RDATA: if (s_ff.bitcnt == BYTE_BITS - 5'h01) begin
          nxt_s.bitcnt = 5'h00;
          if (s_ff.opcode == OP_ARRAY_READ) begin
            nxt_s.addr = addr_next;
            nxt_s.txbyte = mem[addr_next];
          end else begin
            nxt_s.txbyte = st_of(s_ff);
          end
        end
        SECP_WDATA: if (s_ff.bitcnt == BYTE_BITS - 5'h01) begin
          nxt_s.bitcnt = 5'h00;
          nxt_s.byte_ok = 1'b1;
          nxt_s.wr_pending = 1'b1;
          nxt_s.addr = addr_next;
          // Kind is set only in a data phase, so a status read while busy keeps it
          nxt_s.is_status_wr = 1'b0;
          // Bytes are stored as they arrive; a cancelled frame keeps them.
          // Trade-off: no page buffer, the timed cycle only marks busy and then clears the latch.
          if (!locked(s_ff.lock, s_ff.addr)) begin
            nxt_s.mem_we = 1'b1;
            nxt_s.mem_addr = s_ff.addr;
            nxt_s.mem_wdata = {s_ff.shreg[6:0], sbit};
          end
        end
        SECP_SDATA: if (s_ff.bitcnt == BYTE_BITS - 5'h01) begin
          nxt_s.bitcnt = 5'h00;
          nxt_s.byte_ok = 1'b1;
          nxt_s.wr_pending = 1'b1;
          nxt_s.is_status_wr = 1'b1;
          nxt_s.st_new = {s_ff.shreg[6:0], sbit};
          nxt_s.phase = SECP_SKIP;
        end
        SECP_SKIP: nxt_s.bitcnt = 5'h00;
        default: nxt_s.phase = SECP_IDLE;
      endcase
    end else if (cs_low && sck_fall && s_ff.phase == SECP_RDATA) begin
      // Output moves only on the falling serial edge, MSB first
      nxt_s.out.so_oe = 1'b1;
      nxt_s.out.so = s_ff.txbyte[3'(BYTE_BITS - 5'h01 - s_ff.bitcnt)];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
      s_ff.cs_sync <= 3'h7;
      s_ff.phase <= SECP_SKIP;
      // Nonvolatile bits start clear; no power-up image here
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Array write port, kept out of reset on purpose
  always_ff @(posedge clk_sys) begin
    if (s_ff.mem_we) begin
      mem[s_ff.mem_addr] <= s_ff.mem_wdata;
    end
  end

  assign so = s_ff.out.so;
  assign so_oe = s_ff.out.so_oe;
  assign status_byte = st_of(s_ff);

  // ****************************************
  // Checks
  // ****************************************
  AST_HIZ_DESEL: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ff.cs_sync[2] && s_ff.cs_sync[1] |=> !so_oe) else $error("Output driven while deselected");
  AST_ZERO_BITS: assert property (@(posedge clk_sys) disable iff (!rstn)
    status_byte[5:4] == 2'b00) else $error("Status reserved bits not zero");
  AST_NO_WR_NO_LATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.busy) |-> $past(s_ff.latch)) else $error("Write started with latch clear");
  AST_LATCH_DONE: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(s_ff.busy) |-> !s_ff.latch) else $error("Latch not cleared after write");
  AST_LOCK_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ff.mem_we |-> !locked(s_ff.lock, s_ff.mem_addr)) else $error("Locked address written");
  AST_SO_FALL: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(so) |-> $past(sck_fall)) else $error("Output moved off falling edge");
  AST_PROT: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ff.phase == SECP_IDLE && nxt_s.phase == SECP_SDATA |-> !(s_ff.prot_en && !s_ff.wp_sync[1]))
    else $error("Status write accepted while protected");
  AST_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(s_ff.flag) |-> s_ff.opcode_done && s_ff.opcode == OP_LATCH_CLEAR)
    else $error("Flag cleared without opcode");
  AST_BUSY_LEN: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.busy) |-> s_ff.busy [*8]) else $error("Busy dropped too early");
  // Latch ops are held off while busy, so only idle decodes are checked
  AST_LATCH_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && s_ff.opcode == OP_LATCH_SET && !$past(s_ff.busy)
    |-> s_ff.latch)
    else $error("Latch not set by latch-set opcode");
  // The clear opcode drops the user flag together with the latch
  AST_LATCH_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && s_ff.opcode == OP_LATCH_CLEAR && !$past(s_ff.busy)
    |-> !s_ff.latch && !s_ff.flag)
    else $error("Latch or flag not cleared");
  // Flag set is honoured even during a write cycle
  AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && s_ff.opcode == OP_FLAG_SET
    |-> s_ff.flag)
    else $error("Flag not set by flag-set opcode");
  // Without the latch the rest of a write frame is skipped
  AST_WR_NEEDS_LATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && !$past(s_ff.latch) &&
    (s_ff.opcode == OP_ARRAY_WRITE || s_ff.opcode == OP_STATUS_WRITE)
    |-> s_ff.phase == SECP_SKIP)
    else $error("Write accepted with latch clear");
  // Locked mode is judged on the pin level seen at the opcode
  AST_SKIP_PROT: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && s_ff.opcode == OP_STATUS_WRITE &&
    $past(s_ff.prot_en) && !$past(s_ff.wp_sync[1])
    |-> s_ff.phase == SECP_SKIP)
    else $error("Status write not refused in locked mode");
  // Enable clear or pin high must let a latched status write through
  AST_OPEN_SWR: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && s_ff.opcode == OP_STATUS_WRITE && $past(s_ff.latch) &&
    !$past(s_ff.busy) && !($past(s_ff.prot_en) && !$past(s_ff.wp_sync[1]))
    |-> s_ff.phase == SECP_SDATA)
    else $error("Status write refused while open");
  // Busy must last the whole programmed write time
  AST_BUSY_FULL: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(s_ff.busy)
    |-> $past(s_ff.busy_cnt) == 32'(WRITE_CYCLES_P - 1))
    else $error("Busy ended before write time");
  // A started status write commits whatever the pin does meanwhile
  AST_STATUS_COMMIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(s_ff.busy) && $past(s_ff.is_status_wr)
    |-> s_ff.prot_en == $past(s_ff.st_new[ST_PROT_EN]) &&
    s_ff.lock == $past(s_ff.st_new[ST_LOCK_HI:ST_LOCK_LO]))
    else $error("Status write not committed");
  // A write starts only on a select rise at a byte boundary
  AST_LAUNCH_EDGE: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.busy)
    |-> $past(cs_rise) && $past(s_ff.byte_ok) && $past(s_ff.bitcnt) == 5'h00)
    else $error("Write launched off a byte boundary");
  // Every frame counts its first bit from zero
  AST_FIRST_BIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_fall
    |=> s_ff.phase == SECP_IDLE && s_ff.bitcnt == 5'h00)
    else $error("Frame did not restart at bit zero");
  // A parked serial clock must not move the bit position
  AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_low && !cs_fall && !sck_rise
    |=> $stable(s_ff.bitcnt) && $stable(s_ff.shreg))
    else $error("Bit position moved without a clock");
  // Each rising serial edge shifts in exactly one bit at the bottom
  AST_SHIFT_IN: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_low && !cs_fall && sck_rise
    |=> s_ff.shreg == {$past(s_ff.shreg[6:0]), $past(sbit)})
    else $error("Serial bit not shifted in");
  // The read address steps once per byte and wraps at the top
  AST_RD_WRAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_low && !cs_fall && sck_rise && s_ff.phase == SECP_RDATA &&
    s_ff.opcode == OP_ARRAY_READ && s_ff.bitcnt == BYTE_BITS - 5'h01
    |=> s_ff.addr == $past(s_ff.addr) + 16'h0001)
    else $error("Read address did not advance");
  // Status read snapshots the live busy bit, even mid-write
  AST_STATUS_SNAP: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(s_ff.opcode_done) && s_ff.opcode == OP_STATUS_READ
    |-> s_ff.phase == SECP_RDATA && s_ff.txbyte[ST_BUSY] == $past(s_ff.busy))
    else $error("Status read missed busy bit");
  // The output is only driven inside a selected read phase
  AST_OE_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(so_oe)
    |-> s_ff.phase == SECP_RDATA && $past(cs_low))
    else $error("Output enabled outside a read");
endmodule
`default_nettype wire

// file: src/secp_pkg.sv
// Package of constants and types for the serial EEPROM command and protection block
package secp_pkg;
  // Opcodes
  localparam logic [7:0] OP_FLAG_SET = 8'h00;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_LOCK_LO = 2;
  localparam int ST_LOCK_HI = 3;
  localparam int ST_FLAG = 6;
  localparam int ST_PROT_EN = 7;
  // Protected ranges
  localparam logic [15:0] LOCK_QUARTER_BASE = 16'h0c00;
  localparam logic [15:0] LOCK_HALF_BASE = 16'h0800;
  localparam logic [15:0] LOCK_TOP = 16'h0fff;
  localparam logic [15:0] LOCK_ALL_BASE = 16'h0000;
  // Field sizes
  localparam logic [4:0] ADDR_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  // Nonvolatile write time
  localparam int WRITE_TIME_US = 5;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;

  typedef enum logic [5:0] {
    SECP_IDLE = 6'h01,
    SECP_ADDR = 6'h02,
    SECP_RDATA = 6'h04,
    SECP_WDATA = 6'h08,
    SECP_SDATA = 6'h10,
    SECP_SKIP = 6'h20
  } secp_phase_t;

  // Serial output pin group
  typedef struct packed {
    logic so;
    logic so_oe;
  } secp_out_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] si_sync;
    logic [1:0] wp_sync;
    secp_phase_t phase;
    logic [7:0] shreg;
    logic [4:0] bitcnt;
    logic [7:0] opcode;
    logic opcode_done;
    logic [15:0] addr;
    logic [7:0] txbyte;
    logic byte_ok;
    logic wr_pending;
    logic is_status_wr;
    logic [7:0] st_new;
    logic latch;
    logic flag;
    logic prot_en;
    logic [1:0] lock;
    logic busy;
    logic [31:0] busy_cnt;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    secp_out_t out;
  } secp_state_t;
endpackage

// file: sim/secp_host.sv
// Host controller model that drives the serial link in mode 0
`timescale 1ns/1ns
`default_nettype none
module secp_host
  import secp_pkg::*;
(
  // System
  input wire logic clk_sys,
  // Link pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  // ****************************
  // Frame and bit tasks
  // ****************************
  int pause_ns = 0;

  // Idle link: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Select stays low for the whole frame
  task automatic start();
    @(negedge clk_sys);
    cs_n <= 1'b0;
    // Odd offset keeps every sck and si edge inside a byte clear of both system clock edges; select moves on a falling edge
    #201;
  endtask

  // Only called after bit 0 of a whole byte, so writes launch
  task automatic stop();
    #100;
    @(negedge clk_sys);
    cs_n <= 1'b1;
    si <= ~si; // Released line must not keep a stale level
    #200;
  endtask

  // One byte each way, most significant bit first; a pause mid-byte tests a stopped clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #63;
      rx[i] = so_oe ? so : 1'bz;
      sck = 1'b1;
      #62;
      sck = 1'b0;
      if (i == 4) begin
        #(pause_ns);
      end
    end
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking testbench for the command and protection block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import secp_pkg::*;
  // ****************************
  // Clock, reset and instances
  // ****************************
  logic clk_sys;
  logic rstn;
  logic wp_n;
  wire logic cs_n;
  wire logic sck;
  wire logic si;
  wire logic so;
  wire logic so_oe;
  wire logic [7:0] status_byte;
  int error_cnt = 0;
  int compares = 0;

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Short write time so busy spans a status read but the run stays brief
  secp_core #(.WRITE_CYCLES_P(300)) secp_core_i (
    .clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so), .so_oe(so_oe), .wp_n(wp_n), .status_byte(status_byte));
  secp_host secp_host_i (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

  // ****************************
  // Shared tasks
  // ****************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op1(input logic [7:0] op);
    logic [7:0] r;
    secp_host_i.start();
    secp_host_i.xfer(op, r);
    secp_host_i.stop();
  endtask

  task automatic rd_st(input logic [7:0] e, input logic [7:0] m);
    logic [7:0] r;
    secp_host_i.start();
    secp_host_i.xfer(OP_STATUS_READ, r);
    secp_host_i.xfer(8'h00, r);
    secp_host_i.stop();
    chk(r & m, e & m);
  endtask

  // Latch set travels in its own frame before the write frame
  task automatic st_wr(input logic [7:0] v, input logic en);
    logic [7:0] r;
    if (en) op1(OP_LATCH_SET);
    secp_host_i.start();
    secp_host_i.xfer(OP_STATUS_WRITE, r);
    secp_host_i.xfer(v, r);
    secp_host_i.stop();
  endtask

  task automatic arr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d0,
                     input logic [7:0] d1, input logic en);
    logic [7:0] r;
    if (en) op1(OP_LATCH_SET);
    secp_host_i.start();
    secp_host_i.xfer(op, r);
    secp_host_i.xfer(a[15:8], r);
    secp_host_i.xfer(a[7:0], r);
    secp_host_i.xfer(d0, r);
    if (op == OP_ARRAY_READ) chk(r, d0);
    secp_host_i.xfer(d1, r);
    if (op == OP_ARRAY_READ) chk(r, d1);
    secp_host_i.stop();
  endtask

  // Bounded wait for the write cycle to end
  task automatic settle();
    repeat (10) @(negedge clk_sys);
    for (int i = 0; i < 1000 && status_byte[ST_BUSY] !== 1'b0; i++) @(negedge clk_sys);
    chk({7'h00, status_byte[ST_BUSY]}, 8'h00);
  endtask

  // ****************************
  // Test sequence
  // ****************************
  initial begin
    wp_n = 1'b1;
    rstn = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(status_byte, 8'h00);
    chk({7'h00, so_oe}, 8'h00);
    rd_st(8'h00, 8'hff);
    op1(OP_FLAG_SET);
    rd_st(8'h40, 8'hff);
    op1(OP_LATCH_SET);
    rd_st(8'h42, 8'hff);
    op1(OP_LATCH_CLEAR);
    rd_st(8'h00, 8'hff);
    st_wr(8'h8c, 1'b0);
    settle();
    rd_st(8'h00, 8'hff);
    st_wr(8'h8c, 1'b1);
    rd_st(8'h01, 8'h01);
    settle();
    rd_st(8'h8c, 8'hff);
    st_wr(8'h84, 1'b1);
    @(negedge clk_sys);
    wp_n = 1'b0;
    settle();
    rd_st(8'h84, 8'hff);
    st_wr(8'h00, 1'b1);
    settle();
    rd_st(8'h86, 8'hff);
    @(negedge clk_sys);
    wp_n = 1'b1;
    st_wr(8'h00, 1'b0);
    settle();
    rd_st(8'h00, 8'hff);
    arr(OP_ARRAY_WRITE, 16'h07ff, 8'h3c, 8'hc3, 1'b1);
    settle();
    arr(OP_ARRAY_READ, 16'h07ff, 8'h3c, 8'hc3, 1'b0);
    arr(OP_ARRAY_WRITE, 16'hffff, 8'h77, 8'h88, 1'b1);
    settle();
    arr(OP_ARRAY_READ, 16'hffff, 8'h77, 8'h88, 1'b0);
    arr(OP_ARRAY_WRITE, 16'h07ff, 8'h55, 8'h55, 1'b0);
    settle();
    arr(OP_ARRAY_READ, 16'h07ff, 8'h3c, 8'hc3, 1'b0);
    @(negedge clk_sys);
    wp_n = 1'b0;
    st_wr(8'h08, 1'b1);
    settle();
    rd_st(8'h08, 8'hff);
    arr(OP_ARRAY_WRITE, 16'h07ff, 8'h11, 8'h22, 1'b1);
    settle();
    arr(OP_ARRAY_READ, 16'h07ff, 8'h11, 8'hc3, 1'b0);
    secp_host_i.pause_ns = 3000;
    rd_st(8'h08, 8'hff);
    secp_host_i.pause_ns = 0;
    chk({7'h00, so_oe}, 8'h00);
    summarize();
  end

  // Watchdog: the sequence needs well under 300 us
  initial begin
    #600000;
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
